/* shared/regulator_power_sequencer_map.svh */
// Timing constants and reset values for the regulator power sequencer
`ifndef REGULATOR_POWER_SEQUENCER_MAP_SVH
`define REGULATOR_POWER_SEQUENCER_MAP_SVH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define SEQ_CLK_RATE_KHZ 20000
`define SEQ_TICK_CYCLES (`SEQ_CLK_RATE_KHZ / 1000)
`define SEQ_TICK_CNT_W 5

// ----------------------------------------------------------------
// Delays and windows, in microseconds
// ----------------------------------------------------------------
`define SEQ_FLAG_LAG_US 6
`define SEQ_DEBOUNCE_US 32000
`define SEQ_RESET_DLY_US 20000
`define SEQ_REG_DLY_STD_US 125
`define SEQ_REG_DLY_OPT_US 10000
`define SEQ_HOLD_UP_US 500000

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SEQ_TIMER_W 20
`define SEQ_LAG_W 4
`define SEQ_RST_N_RESET 1'h0
`define SEQ_IRQ_N_RESET 1'h1
`define SEQ_EN_RESET 1'h0

`endif

/* shared/regulator_power_sequencer_pkg.sv */
// Types shared by the regulator power sequencer
`default_nettype none
package regulator_power_sequencer_pkg;

    // Comparator view of one regulator output
    typedef struct packed {
        logic above_rise;
        logic below_fall;
    } reg_sense_s;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_DEBOUNCE,
        ST_A_RAMP,
        ST_A_DELAY,
        ST_B_RAMP,
        ST_RST_DELAY,
        ST_HOLD_WAIT,
        ST_RUN,
        ST_PD_RST,
        ST_PD_B_FALL,
        ST_PD_A_DELAY
    } seq_state_e;

endpackage
`default_nettype wire

/* hw/pg_flag_filter.sv */
// Power-good flag with hysteresis and bounded response lag
`timescale 1ns/100ps
`default_nettype none
`include "regulator_power_sequencer_map.svh"
module pg_flag_filter #(
    parameter int LAG_US = `SEQ_FLAG_LAG_US
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire regulator_power_sequencer_pkg::reg_sense_s i_sense,
    output logic o_flag
);
    localparam logic [`SEQ_LAG_W-1:0] LAG_LIM = `SEQ_LAG_W'(LAG_US);

    if (LAG_US < 1 || LAG_US > 9) begin : g_chk
        $error("pg_flag_filter: lag must stay below the 10 us limit");
    end

    logic flag_q, flag_d;
    logic [`SEQ_LAG_W-1:0] lag_q, lag_d;
    logic want;

    // ----------------------------------------------------------------
    // Hysteresis and lag
    // ----------------------------------------------------------------
    always_comb begin
        want = flag_q;
        if (i_sense.above_rise) begin
            want = 1'h1;
        end else if (i_sense.below_fall) begin
            want = 1'h0;
        end
        flag_d = flag_q;
        lag_d = '0;
        if (want != flag_q) begin
            lag_d = lag_q;
            if (i_tick) begin
                if (lag_q >= LAG_LIM - `SEQ_LAG_W'(1)) begin
                    flag_d = want;
                    lag_d = '0;
                end else begin
                    lag_d = lag_q + `SEQ_LAG_W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_q <= 1'h0;
            lag_q <= '0;
        end else begin
            flag_q <= flag_d;
            lag_q <= lag_d;
        end
    end

    assign o_flag = flag_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_rise_sets_flag: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sense.above_rise && !flag_q) |-> ##[1:200] (flag_q || !i_sense.above_rise))
        else $error("flag did not set after rise crossing");
    a_fall_clears_flag: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sense.below_fall && !i_sense.above_rise && flag_q)
            |-> ##[1:200] (!flag_q || !i_sense.below_fall || i_sense.above_rise))
        else $error("flag did not clear after fall crossing");
    a_flag_hysteresis: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(flag_q) |-> $past(i_sense.above_rise || i_sense.below_fall))
        else $error("flag moved without a threshold crossing");

endmodule // pg_flag_filter
`default_nettype wire

/* hw/regulator_power_sequencer.sv */
// Power-up and power-down sequencer for two main regulators
// Contract
// - Power-good flags stay internal; they only steer the sequence.
// - Flag sets when the output reaches the rise threshold.
// - Flag clears at the fall threshold; hysteresis in between.
// - Each flag follows its crossing within 10 us, 6 us typical.
// - Reset released a reset delay after regulator B flag sets.
// - Power-down: regulator B disabled a reset delay after reset drops.
// - Regulator B enabled a regulator delay after regulator A flag sets.
// - Power-down: regulator A disabled a regulator delay after B flag clears.
// - Regulator delay selectable at build time: 125 us or 10 ms.
// - Hold-up window starts at reset release; host raises power-hold within it.
// - Key debounced over 32 ms asserts interrupt and enables regulator A.
// - Hold in time clears interrupt; window expiry clears it and, with no charger present, powers down.
// - Loss of either flag drives reset low at once.
// - With charger present no power-down except on flag loss; otherwise needs charger gone and hold low.
`timescale 1ns/100ps
`default_nettype none
`include "regulator_power_sequencer_map.svh"
module regulator_power_sequencer #(
    parameter bit LONG_REG_DLY = 1'b0,
    parameter int TIMER_W = `SEQ_TIMER_W,
    parameter int DEBOUNCE_US = `SEQ_DEBOUNCE_US,
    parameter int RESET_DLY_US = `SEQ_RESET_DLY_US,
    parameter int REG_DLY_US = LONG_REG_DLY ? `SEQ_REG_DLY_OPT_US : `SEQ_REG_DLY_STD_US,
    parameter int HOLD_UP_US = `SEQ_HOLD_UP_US
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_POWER_KEY_INPUT,
    input wire logic I_CHARGER_DETECT_N,
    input wire logic I_POWER_HOLD_INPUT,
    input wire regulator_power_sequencer_pkg::reg_sense_s I_REGULATOR_A_SENSE,
    input wire regulator_power_sequencer_pkg::reg_sense_s I_REGULATOR_B_SENSE,
    output logic O_REGULATOR_A_EN,
    output logic O_REGULATOR_B_EN,
    output logic O_RST_N,
    output logic O_KEY_IRQ_N
);
    localparam logic [TIMER_W-1:0] DEBOUNCE_LIM = TIMER_W'(DEBOUNCE_US);
    localparam logic [TIMER_W-1:0] RESET_LIM = TIMER_W'(RESET_DLY_US);
    localparam logic [TIMER_W-1:0] REG_LIM = TIMER_W'(REG_DLY_US);
    localparam logic [TIMER_W-1:0] HOLD_LIM = TIMER_W'(HOLD_UP_US);
    localparam logic [`SEQ_TICK_CNT_W-1:0] TICK_LAST = `SEQ_TICK_CNT_W'(`SEQ_TICK_CYCLES - 1);

    if (TIMER_W < 2 || TIMER_W > 30 ||
        DEBOUNCE_US < 1 || RESET_DLY_US < 1 || REG_DLY_US < 1 || HOLD_UP_US < 1 ||
        DEBOUNCE_US >= (1 << TIMER_W) - 1 || RESET_DLY_US >= (1 << TIMER_W) - 1 ||
        REG_DLY_US >= (1 << TIMER_W) - 1 || HOLD_UP_US >= (1 << TIMER_W) - 1) begin : g_chk
        $error("regulator_power_sequencer: delays do not fit the timer");
    end

    // Limit reached: timer counts whole microseconds since state entry
    function automatic logic reached(input logic [TIMER_W-1:0] t,
                                     input logic [TIMER_W-1:0] lim);
        reached = (t >= lim);
    endfunction

    // ----------------------------------------------------------------
    // Microsecond time base
    // ----------------------------------------------------------------
    logic [`SEQ_TICK_CNT_W-1:0] div_q, div_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = 1'h0;
        div_d = div_q + `SEQ_TICK_CNT_W'(1);
        if (div_q == TICK_LAST) begin
            div_d = '0;
            tick_d = 1'h1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            div_q <= '0;
            tick_q <= 1'h0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------------------------------
    // Internal power-good flags
    // ----------------------------------------------------------------
    logic flag_a, flag_b;

    // Flags never leave the block
    pg_flag_filter u_flag_a (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_tick(tick_q),
        .i_sense(I_REGULATOR_A_SENSE),
        .o_flag(flag_a)
    );

    pg_flag_filter u_flag_b (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_tick(tick_q),
        .i_sense(I_REGULATOR_B_SENSE),
        .o_flag(flag_b)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    regulator_power_sequencer_pkg::seq_state_e state_q, state_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic en_a_q, en_a_d;
    logic en_b_q, en_b_d;
    logic rst_n_q, rst_n_d;
    logic irq_n_q, irq_n_d;
    logic key_start_q, key_start_d;
    logic charger_on, start_cond, flag_lost, shutdown_req;

    always_comb begin
        charger_on = !I_CHARGER_DETECT_N;
        start_cond = I_POWER_KEY_INPUT || charger_on;
        flag_lost = !flag_a || !flag_b;
        shutdown_req = !I_POWER_HOLD_INPUT && !charger_on;
        state_d = state_q;
        en_a_d = en_a_q;
        en_b_d = en_b_q;
        rst_n_d = rst_n_q;
        irq_n_d = irq_n_q;
        key_start_d = key_start_q;
        timer_d = timer_q;
        if (tick_q && timer_q != '1) begin
            timer_d = timer_q + TIMER_W'(1);
        end
        case (state_q)
            regulator_power_sequencer_pkg::ST_OFF: begin
                timer_d = '0;
                if (start_cond) begin
                    key_start_d = !charger_on;
                    state_d = regulator_power_sequencer_pkg::ST_DEBOUNCE;
                end
            end
            regulator_power_sequencer_pkg::ST_DEBOUNCE: begin
                if (key_start_q ? !I_POWER_KEY_INPUT : !charger_on) begin
                    state_d = regulator_power_sequencer_pkg::ST_OFF;
                end else if (timer_q > DEBOUNCE_LIM) begin
                    en_a_d = 1'h1;
                    irq_n_d = !key_start_q;
                    timer_d = '0;
                    state_d = regulator_power_sequencer_pkg::ST_A_RAMP;
                end
            end
            regulator_power_sequencer_pkg::ST_A_RAMP: begin
                timer_d = '0;
                if (flag_a) begin
                    state_d = regulator_power_sequencer_pkg::ST_A_DELAY;
                end
            end
            regulator_power_sequencer_pkg::ST_A_DELAY: begin
                if (!flag_a) begin
                    timer_d = '0;
                    state_d = regulator_power_sequencer_pkg::ST_A_RAMP;
                end else if (reached(timer_q, REG_LIM)) begin
                    en_b_d = 1'h1;
                    state_d = regulator_power_sequencer_pkg::ST_B_RAMP;
                end
            end
            regulator_power_sequencer_pkg::ST_B_RAMP: begin
                timer_d = '0;
                if (flag_b && flag_a) begin
                    state_d = regulator_power_sequencer_pkg::ST_RST_DELAY;
                end
            end
            regulator_power_sequencer_pkg::ST_RST_DELAY: begin
                if (flag_lost) begin
                    timer_d = '0;
                    state_d = regulator_power_sequencer_pkg::ST_B_RAMP;
                end else if (reached(timer_q, RESET_LIM)) begin
                    rst_n_d = 1'h1;
                    timer_d = '0;
                    state_d = regulator_power_sequencer_pkg::ST_HOLD_WAIT;
                end
            end
            regulator_power_sequencer_pkg::ST_HOLD_WAIT: begin
                if (flag_lost) begin
                    rst_n_d = 1'h0;
                    irq_n_d = 1'h1;
                    timer_d = '0;
                    state_d = regulator_power_sequencer_pkg::ST_PD_RST;
                end else if (I_POWER_HOLD_INPUT) begin
                    irq_n_d = 1'h1;
                    state_d = regulator_power_sequencer_pkg::ST_RUN;
                end else if (reached(timer_q, HOLD_LIM)) begin
                    irq_n_d = 1'h1;
                    if (charger_on) begin
                        state_d = regulator_power_sequencer_pkg::ST_RUN;
                    end else begin
                        rst_n_d = 1'h0;
                        timer_d = '0;
                        state_d = regulator_power_sequencer_pkg::ST_PD_RST;
                    end
                end
            end
            regulator_power_sequencer_pkg::ST_RUN: begin
                timer_d = '0;
                if (flag_lost || shutdown_req) begin
                    rst_n_d = 1'h0;
                    state_d = regulator_power_sequencer_pkg::ST_PD_RST;
                end
            end
            regulator_power_sequencer_pkg::ST_PD_RST: begin
                if (reached(timer_q, RESET_LIM)) begin
                    en_b_d = 1'h0;
                    state_d = regulator_power_sequencer_pkg::ST_PD_B_FALL;
                end
            end
            regulator_power_sequencer_pkg::ST_PD_B_FALL: begin
                timer_d = '0;
                if (!flag_b) begin
                    state_d = regulator_power_sequencer_pkg::ST_PD_A_DELAY;
                end
            end
            regulator_power_sequencer_pkg::ST_PD_A_DELAY: begin
                if (reached(timer_q, REG_LIM)) begin
                    en_a_d = 1'h0;
                    state_d = regulator_power_sequencer_pkg::ST_OFF;
                end
            end
            default: begin
                state_d = regulator_power_sequencer_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_q <= regulator_power_sequencer_pkg::ST_OFF;
            timer_q <= '0;
            en_a_q <= `SEQ_EN_RESET;
            en_b_q <= `SEQ_EN_RESET;
            rst_n_q <= `SEQ_RST_N_RESET;
            irq_n_q <= `SEQ_IRQ_N_RESET;
            key_start_q <= 1'h0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            en_a_q <= en_a_d;
            en_b_q <= en_b_d;
            rst_n_q <= rst_n_d;
            irq_n_q <= irq_n_d;
            key_start_q <= key_start_d;
        end
    end

    assign O_REGULATOR_A_EN = en_a_q;
    assign O_REGULATOR_B_EN = en_b_q;
    assign O_RST_N = rst_n_q;
    assign O_KEY_IRQ_N = irq_n_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    sequence s_reset_drop;
        rst_n_q ##1 !rst_n_q;
    endsequence

    sequence s_b_off;
        en_b_q ##1 !en_b_q;
    endsequence

    a_reset_release: assert property (
        $rose(rst_n_q) |-> $past(flag_b) && $past(timer_q) >= RESET_LIM)
        else $error("reset released before reset delay");
    a_b_disable_late: assert property (
        s_b_off |-> !rst_n_q && $past(timer_q) >= RESET_LIM)
        else $error("regulator B disabled too early");
    a_b_enable_after: assert property (
        $rose(en_b_q) |-> $past(flag_a) && $past(timer_q) >= REG_LIM && en_a_q)
        else $error("regulator B enabled without regulator A delay");
    a_a_disable_after: assert property (
        $fell(en_a_q) |-> !en_b_q && $past(timer_q) >= REG_LIM)
        else $error("regulator A disabled out of order");
    a_key_irq_start: assert property (
        $fell(irq_n_q) |-> $rose(en_a_q) && key_start_q)
        else $error("interrupt without key power-up");
    a_hold_clears_irq: assert property (
        (state_q == regulator_power_sequencer_pkg::ST_HOLD_WAIT && I_POWER_HOLD_INPUT
            && flag_a && flag_b) |=> irq_n_q && rst_n_q)
        else $error("power-hold did not clear interrupt");
    a_flag_loss_reset: assert property (
        (state_q == regulator_power_sequencer_pkg::ST_RUN && (!flag_a || !flag_b))
            |=> !rst_n_q)
        else $error("flag loss did not drop reset");
    a_charger_holds_on: assert property (
        (state_q == regulator_power_sequencer_pkg::ST_RUN && !I_CHARGER_DETECT_N && flag_a
            && flag_b) |=> en_a_q && en_b_q && rst_n_q)
        else $error("powered down with charger present");
    a_pd_keeps_b: assert property (
        s_reset_drop |-> en_b_q [*2])
        else $error("regulator B dropped with reset");
    a_tick_period: assert property (
        tick_q |=> !tick_q [*8])
        else $error("time base faster than one microsecond");

endmodule // regulator_power_sequencer
`default_nettype wire

/* verif/sequencer_partner_model.sv */
// Host processor and regulator output models facing the sequencer
`timescale 1ns/100ps
`default_nettype none
// --------------------------------
// Regulator output seen by its two comparators
// --------------------------------
module seq_reg_model #(
    parameter int RAMP = 40
) (
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [1:0] i_sag,
    output var regulator_power_sequencer_pkg::reg_sense_s o_sense
);
    int cnt = RAMP;
    logic en_q = 1'h0;
    always_ff @(posedge i_clk) begin
        en_q <= i_en;
        cnt <= (i_en != en_q) ? 0 : ((cnt < RAMP) ? cnt + 1 : cnt);
    end
    // Sag 1 parks the output between thresholds, sag 2 pulls it under both
    always_comb begin
        o_sense.above_rise = (i_sag == 2'h0) && en_q && (cnt == RAMP);
        o_sense.below_fall = (i_sag == 2'h2) || (!en_q && (cnt == RAMP));
    end
endmodule // seq_reg_model

// --------------------------------
// Host processor holding power after reset release
// --------------------------------
module seq_host_model #(
    parameter int ANSWER_CYC = 100
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_answer,
    output wire logic o_hold
);
    int cnt = 0;
    logic hold_q = 1'h0;
    assign o_hold = hold_q;
    always_ff @(posedge i_clk) begin
        cnt <= i_rst_n ? cnt + 1 : 0;
        hold_q <= i_rst_n && i_answer && (cnt >= ANSWER_CYC);
    end
endmodule // seq_host_model
`default_nettype wire

/* verif/test_regulator_power_sequencer.sv */
// Self-checking bench for the regulator power sequencer
`timescale 1ns/100ps
`default_nettype none
module test_regulator_power_sequencer;
    localparam int TK = 20;
    localparam int DB = 40;
    localparam int RD = 30;
    localparam int GD = 10;
    localparam int HU = 60;
    localparam int LAG = 6;
    logic clk, rst, key, chg_n, answer;
    logic [1:0] sag_a, sag_b;
    logic en_a, en_b, rst_n, irq_n;
    wire logic hold;
    wire regulator_power_sequencer_pkg::reg_sense_s sense_a;
    wire regulator_power_sequencer_pkg::reg_sense_s sense_b;
    int fails = 0;
    int compares = 0;

    regulator_power_sequencer #(.DEBOUNCE_US(DB), .RESET_DLY_US(RD), .REG_DLY_US(GD),
        .HOLD_UP_US(HU)) dut (.I_CLK(clk), .I_RST(rst), .I_POWER_KEY_INPUT(key),
        .I_CHARGER_DETECT_N(chg_n), .I_POWER_HOLD_INPUT(hold),
        .I_REGULATOR_A_SENSE(sense_a), .I_REGULATOR_B_SENSE(sense_b),
        .O_REGULATOR_A_EN(en_a), .O_REGULATOR_B_EN(en_b), .O_RST_N(rst_n),
        .O_KEY_IRQ_N(irq_n));
    seq_reg_model reg_a (.i_clk(clk), .i_en(en_a), .i_sag(sag_a), .o_sense(sense_a));
    seq_reg_model reg_b (.i_clk(clk), .i_en(en_b), .i_sag(sag_b), .o_sense(sense_b));
    seq_host_model host (.i_clk(clk), .i_rst_n(rst_n), .i_answer(answer), .o_hold(hold));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // --------------------------------
    // Shared helpers
    // --------------------------------
    // Codes: 0 en_a 1 en_b 2 rst_n 3 irq_n 4 a good 5 b good 6 b low 7 hold
    function automatic logic pick(input int code);
        case (code)
            0: return en_a;
            1: return en_b;
            2: return rst_n;
            3: return irq_n;
            4: return sense_a.above_rise;
            5: return sense_b.above_rise;
            6: return sense_b.below_fall;
            default: return hold;
        endcase
    endfunction

    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Counts edges until the signal shows val; gives lim if it never does
    task automatic wait_sig(input int code, input logic val, input int lim, output int n);
        n = 0;
        while (pick(code) !== val && n < lim) begin
            step(1);
            n++;
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int n);
        compares++;
        if (n < lo || n > hi) begin
            fails++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, n);
        end
    endtask

    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic power_up(input logic by_key);
        int n;
        if (by_key) begin
            key = 1'h1;
        end else begin
            chg_n = 1'h0;
        end
        wait_sig(0, 1'h1, 2*DB*TK, n);
        check_range("ena_delay", (DB-1)*TK, (DB+3)*TK, n);
        check_bit("irq_n_start", !by_key, irq_n);
        key = 1'h0;
        wait_sig(4, 1'h1, 200, n);
        wait_sig(1, 1'h1, 2000, n);
        check_range("enb_delay", (LAG+GD-1)*TK, (LAG+GD+3)*TK, n);
        wait_sig(5, 1'h1, 200, n);
        wait_sig(2, 1'h1, 2000, n);
        check_range("rst_delay", (LAG+RD-1)*TK, (LAG+RD+3)*TK, n);
        check_bit("irq_n_up", !by_key, irq_n);
    endtask

    task automatic finish_down();
        int n;
        wait_sig(1, 1'h0, 2000, n);
        check_range("enb_off", (RD-1)*TK, (RD+2)*TK, n);
        check_bit("ena_still", 1'h1, en_a);
        wait_sig(6, 1'h1, 200, n);
        wait_sig(0, 1'h0, 2000, n);
        check_range("ena_off", (LAG+GD-1)*TK, (LAG+GD+3)*TK, n);
        check_bit("rst_n_off", 1'h0, rst_n);
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_key();
        int n;
        answer = 1'h1;
        power_up(1'h1);
        wait_sig(7, 1'h1, 2*HU*TK, n);
        wait_sig(3, 1'h1, 10, n);
        check_range("irq_release", 1, 2, n);
        step(2*HU*TK);
        check_bit("run_rst_n", 1'h1, rst_n);
        $display("t_key done");
    endtask

    task automatic t_shut();
        int n;
        answer = 1'h0;
        wait_sig(7, 1'h0, 10, n);
        wait_sig(2, 1'h0, 10, n);
        check_range("rst_on_hold_low", 1, 2, n);
        finish_down();
        $display("t_shut done");
    endtask

    task automatic t_short();
        int n;
        key = 1'h1;
        step((DB-4)*TK);
        key = 1'h0;
        wait_sig(0, 1'h1, 2*DB*TK, n);
        check_range("short_key", 2*DB*TK, 2*DB*TK, n);
        check_bit("irq_quiet", 1'h1, irq_n);
        $display("t_short done");
    endtask

    task automatic t_timeout();
        int n;
        answer = 1'h0;
        power_up(1'h1);
        wait_sig(2, 1'h0, 2*HU*TK, n);
        check_range("hold_window", (HU-1)*TK, (HU+2)*TK, n);
        check_bit("irq_expired", 1'h1, irq_n);
        finish_down();
        $display("t_timeout done");
    endtask

    task automatic t_charger();
        int n;
        answer = 1'h1;
        power_up(1'h0);
        step(HU*TK);
        answer = 1'h0;
        wait_sig(2, 1'h0, 2*HU*TK, n);
        check_range("charger_keeps_on", 2*HU*TK, 2*HU*TK, n);
        chg_n = 1'h1;
        wait_sig(2, 1'h0, 10, n);
        check_range("charger_gone", 1, 2, n);
        finish_down();
        $display("t_charger done");
    endtask

    task automatic t_flag();
        int n;
        answer = 1'h1;
        power_up(1'h1);
        step(HU*TK);
        sag_b = 2'h1;
        step(20*TK);
        check_bit("hysteresis", 1'h1, rst_n);
        sag_b = 2'h0;
        sag_a = 2'h2;
        wait_sig(2, 1'h0, 20*TK, n);
        check_range("flag_loss", (LAG-1)*TK, 11*TK, n);
        finish_down();
        sag_a = 2'h0;
        $display("t_flag done");
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        $display("ERROR watchdog expected done seen hung");
        conclude();
    end

    initial begin
        rst = 1'h1;
        key = 1'h0;
        chg_n = 1'h1;
        answer = 1'h1;
        sag_a = 2'h0;
        sag_b = 2'h0;
        step(5);
        rst = 1'h0;
        step(1);
        check_bit("reset_en_a", 1'h0, en_a);
        check_bit("reset_rst_n", 1'h0, rst_n);
        check_bit("reset_irq_n", 1'h1, irq_n);
        t_key();
        t_shut();
        t_short();
        t_timeout();
        t_charger();
        t_flag();
        conclude();
    end
endmodule // test_regulator_power_sequencer
`default_nettype wire
